// ### hw/lrm_decoder.sv
module lrm_decoder
   import lrm_pkg::*;
(
   input wire logic i_ref_clk,
   input wire logic i_rst_n,
   input wire logic i_ce,
   input wire logic i_start,
   input wire logic [7:0] i_opcode,
   input wire logic [7:0] i_byte1,
   input wire logic [7:0] i_byte2,
   input wire logic [7:0] i_acc,
   input wire logic [7:0] i_psw,
   input wire logic [7:0] i_reg_rdata,
   input wire logic [7:0] i_mem_rdata,
   output logic o_busy,
   output logic o_done,
   output logic o_known,
   output logic [1:0] o_length,
   output logic [2:0] o_cycles,
   output logic [4:0] o_reg_addr,
   output logic [7:0] o_mem_addr,
   output logic o_acc_we,
   output logic [7:0] o_acc_wdata,
   output logic o_parity,
   output logic o_carry_we,
   output logic o_carry,
   output logic o_reg_we,
   output logic [7:0] o_reg_wdata,
   output logic o_mem_we,
   output logic [7:0] o_mem_wdata
);
   timeunit 1ns;
   timeprecision 1ps;

   // Packs one decode entry
   function automatic lrm_dec_t mk(
      input lrm_alu_t alu,
      input lrm_src_t src,
      input lrm_dst_t dst,
      input logic [1:0] len,
      input logic [2:0] cyc
   );
      lrm_dec_t d;
      d.known = 1'b1;
      d.alu = alu;
      d.src = src;
      d.dst = dst;
      d.len = len;
      d.cyc = cyc;
      return d;
   endfunction : mk

   // True when opcode matches a base under a mask
   function automatic logic hit(
      input logic [7:0] op,
      input logic [7:0] base,
      input logic [7:0] mask
   );
      return (op & mask) == base;
   endfunction : hit

   // Opcode table; anything not listed decodes as unknown
   function automatic lrm_dec_t decode(input logic [7:0] op);
      lrm_dec_t d;
      d = '0;
      d.alu = ALU_NONE;
      d.src = SRC_ACC;
      d.dst = DST_ACC;
      if (op == OPC_OR_IMM)
         d = mk(ALU_OR, SRC_IMM1, DST_ACC, LEN_2, CYC_2);
      else if (op == OPC_OR_DIR_ACC)
         d = mk(ALU_OR, SRC_ACC, DST_DIR, LEN_2, CYC_4);
      else if (op == OPC_OR_DIR_IMM)
         d = mk(ALU_OR, SRC_IMM2, DST_DIR, LEN_3, CYC_4);
      else if (hit(op, OPC_XOR_REG, MASK_REG))
         d = mk(ALU_XOR, SRC_REG, DST_ACC, LEN_1, CYC_2);
      else if (op == OPC_XOR_DIR)
         d = mk(ALU_XOR, SRC_DIR, DST_ACC, LEN_2, CYC_3);
      else if (hit(op, OPC_XOR_IND, MASK_IND))
         d = mk(ALU_XOR, SRC_IND, DST_ACC, LEN_1, CYC_4);
      else if (op == OPC_XOR_IMM)
         d = mk(ALU_XOR, SRC_IMM1, DST_ACC, LEN_2, CYC_2);
      else if (op == OPC_XOR_DIR_ACC)
         d = mk(ALU_XOR, SRC_ACC, DST_DIR, LEN_2, CYC_4);
      else if (op == OPC_XOR_DIR_IMM)
         d = mk(ALU_XOR, SRC_IMM2, DST_DIR, LEN_3, CYC_4);
      else if (op == OPC_CLR)
         d = mk(ALU_CLR, SRC_ACC, DST_ACC, LEN_1, CYC_1);
      else if (op == OPC_CPL)
         d = mk(ALU_CPL, SRC_ACC, DST_ACC, LEN_1, CYC_1);
      else if (op == OPC_RL)
         d = mk(ALU_RL, SRC_ACC, DST_ACC, LEN_1, CYC_1);
      else if (op == OPC_RLC)
         d = mk(ALU_RLC, SRC_ACC, DST_ACC, LEN_1, CYC_1);
      else if (op == OPC_RR)
         d = mk(ALU_RR, SRC_ACC, DST_ACC, LEN_1, CYC_1);
      else if (op == OPC_RRC)
         d = mk(ALU_RRC, SRC_ACC, DST_ACC, LEN_1, CYC_1);
      else if (op == OPC_SWAP)
         d = mk(ALU_SWAP, SRC_ACC, DST_ACC, LEN_1, CYC_1);
      else if (hit(op, OPC_MOV_A_REG, MASK_REG))
         d = mk(ALU_MOVE, SRC_REG, DST_ACC, LEN_1, CYC_1);
      else if (op == OPC_MOV_A_DIR)
         d = mk(ALU_MOVE, SRC_DIR, DST_ACC, LEN_2, CYC_3);
      else if (hit(op, OPC_MOV_A_IND, MASK_IND))
         d = mk(ALU_MOVE, SRC_IND, DST_ACC, LEN_1, CYC_4);
      else if (op == OPC_MOV_A_IMM)
         d = mk(ALU_MOVE, SRC_IMM1, DST_ACC, LEN_2, CYC_2);
      else if (hit(op, OPC_MOV_REG_A, MASK_REG))
         d = mk(ALU_MOVE, SRC_ACC, DST_REG, LEN_1, CYC_1);
      else if (hit(op, OPC_MOV_REG_DIR, MASK_REG))
         d = mk(ALU_MOVE, SRC_DIR, DST_REG, LEN_2, CYC_4);
      else if (hit(op, OPC_MOV_REG_IMM, MASK_REG))
         d = mk(ALU_MOVE, SRC_IMM1, DST_REG, LEN_2, CYC_2);
      return d;
   endfunction : decode

   // Result byte with carry out on top
   function automatic logic [8:0] alu_f(
      input lrm_alu_t alu,
      input logic [7:0] a,
      input logic [7:0] b,
      input logic c
   );
      logic [8:0] r;
      r = {c, a};
      case (alu)
         ALU_OR: r = {c, a | b};
         ALU_XOR: r = {c, a ^ b};
         ALU_CLR: r = {c, 8'h00};
         ALU_CPL: r = {c, ~a};
         ALU_RL: r = {c, a[6:0], a[7]};
         ALU_RLC: r = {a[7], a[6:0], c};
         ALU_RR: r = {c, a[0], a[7:1]};
         ALU_RRC: r = {a[0], c, a[7:1]};
         ALU_SWAP: r = {c, a[3:0], a[7:4]};
         ALU_MOVE: r = {c, b};
         default: r = {c, a};
      endcase
      return r;
   endfunction : alu_f

   lrm_dec_t dec_now;
   lrm_dec_t dec_reg;
   logic busy_reg;
   logic first_reg;
   logic [2:0] cnt_reg;
   logic [7:0] imm1_reg;
   logic [7:0] imm2_reg;
   logic take;
   logic finish;
   logic [2:0] reg_idx;
   logic [1:0] bank;
   logic [7:0] b_val;
   logic [7:0] a_val;
   logic [8:0] res;
   logic carry_rot;

   // Decode of the offered opcode and start qualifier
   assign dec_now = decode(i_opcode);
   assign take = i_start && !busy_reg;
   assign finish = busy_reg && (cnt_reg == 3'h0);

   assign bank = {i_psw[PSW_BANK_HI_BIT], i_psw[PSW_BANK_LO_BIT]};
   assign reg_idx = hit(i_opcode, OPC_XOR_IND, MASK_IND) ||
                    hit(i_opcode, OPC_MOV_A_IND, MASK_IND) ?
                    {2'b00, i_opcode[0]} : i_opcode[2:0];

   // Operand selection; reads are sampled on the final edge
   assign b_val = (dec_reg.src == SRC_IMM1) ? imm1_reg :
                  (dec_reg.src == SRC_IMM2) ? imm2_reg :
                  (dec_reg.src == SRC_REG) ? i_reg_rdata :
                  (dec_reg.src == SRC_ACC) ? i_acc : i_mem_rdata;
   assign a_val = (dec_reg.dst == DST_DIR) ? i_mem_rdata : i_acc;
   assign res = alu_f(dec_reg.alu, a_val, b_val,
                      i_psw[PSW_CARRY_BIT]);
   // carry touched only by carry rotates
   assign carry_rot = (dec_reg.alu == ALU_RLC) ||
                      (dec_reg.alu == ALU_RRC);

   // Sequencer: count down the cycle budget of the instruction.
   // Unknown opcodes are refused so the core can trap them itself.
   always_ff @(posedge i_ref_clk) begin
      if (!i_rst_n) begin
         busy_reg <= 1'b0;
         first_reg <= 1'b0;
         cnt_reg <= 3'h0;
         dec_reg <= '0;
         imm1_reg <= BYTE_RST;
         imm2_reg <= BYTE_RST;
      end else if (i_ce) begin
         first_reg <= take;
         if (take && dec_now.known) begin
            busy_reg <= 1'b1;
            cnt_reg <= dec_now.cyc - 3'h1;
            dec_reg <= dec_now;
            imm1_reg <= i_byte1;
            imm2_reg <= i_byte2;
         end else if (finish) begin
            busy_reg <= 1'b0;
         end else if (busy_reg) begin
            cnt_reg <= cnt_reg - 3'h1;
         end
      end
   end

   // Decode report, held until the next start
   always_ff @(posedge i_ref_clk) begin
      if (!i_rst_n) begin
         o_known <= 1'b0;
         o_length <= 2'h0;
         o_cycles <= 3'h0;
      end else if (i_ce && take) begin
         o_known <= dec_now.known;
         o_length <= dec_now.len;
         o_cycles <= dec_now.cyc;
      end
   end

   // Addresses: pointer value replaces the direct address one
   // edge after start, so indirect forms need at least two cycles
   always_ff @(posedge i_ref_clk) begin
      if (!i_rst_n) begin
         o_reg_addr <= RADDR_RST;
         o_mem_addr <= BYTE_RST;
      end else if (i_ce) begin
         if (take && dec_now.known) begin
            o_reg_addr <= {bank, reg_idx};
            o_mem_addr <= i_byte1;
         end else if (first_reg && busy_reg &&
                      dec_reg.src == SRC_IND) begin
            o_mem_addr <= i_reg_rdata;
         end
      end
   end

   // Write-back strobes pulse for one cycle on the final edge
   always_ff @(posedge i_ref_clk) begin
      if (!i_rst_n) begin
         o_done <= 1'b0;
         o_acc_we <= 1'b0;
         o_reg_we <= 1'b0;
         o_mem_we <= 1'b0;
         o_carry_we <= 1'b0;
      end else if (i_ce) begin
         o_done <= finish;
         o_acc_we <= finish && dec_reg.dst == DST_ACC;
         o_reg_we <= finish && dec_reg.dst == DST_REG;
         o_mem_we <= finish && dec_reg.dst == DST_DIR;
         // carry strobe for rotates via carry
         o_carry_we <= finish && carry_rot;
      end
   end

   // Write data holds after the strobe for easy sampling
   always_ff @(posedge i_ref_clk) begin
      if (!i_rst_n) begin
         o_acc_wdata <= BYTE_RST;
         o_reg_wdata <= BYTE_RST;
         o_mem_wdata <= BYTE_RST;
         o_parity <= 1'b0;
         o_carry <= 1'b0;
      end else if (i_ce && finish) begin
         o_acc_wdata <= res[7:0];
         o_reg_wdata <= res[7:0];
         o_mem_wdata <= res[7:0];
         o_carry <= res[8];
         if (dec_reg.dst == DST_ACC)
            o_parity <= ^res[7:0];
      end
   end

   // Busy mirrors the sequencer
   assign o_busy = busy_reg;

endmodule : lrm_decoder

// ### hw/lrm_pkg.sv
package lrm_pkg;
   // Opcode bases; register forms ignore the low three bits
   localparam logic [7:0] OPC_OR_IMM = 8'h44;
   localparam logic [7:0] OPC_OR_DIR_ACC = 8'h42;
   localparam logic [7:0] OPC_OR_DIR_IMM = 8'h43;
   localparam logic [7:0] OPC_XOR_REG = 8'h68;
   localparam logic [7:0] OPC_XOR_DIR = 8'h65;
   localparam logic [7:0] OPC_XOR_IND = 8'h66;
   localparam logic [7:0] OPC_XOR_IMM = 8'h64;
   localparam logic [7:0] OPC_XOR_DIR_ACC = 8'h62;
   localparam logic [7:0] OPC_XOR_DIR_IMM = 8'h63;
   localparam logic [7:0] OPC_CLR = 8'he4;
   localparam logic [7:0] OPC_CPL = 8'hf4;
   localparam logic [7:0] OPC_RL = 8'h23;
   localparam logic [7:0] OPC_RLC = 8'h33;
   localparam logic [7:0] OPC_RR = 8'h03;
   localparam logic [7:0] OPC_RRC = 8'h13;
   localparam logic [7:0] OPC_SWAP = 8'hc4;
   localparam logic [7:0] OPC_MOV_A_REG = 8'he8;
   localparam logic [7:0] OPC_MOV_A_DIR = 8'he5;
   localparam logic [7:0] OPC_MOV_A_IND = 8'he6;
   localparam logic [7:0] OPC_MOV_A_IMM = 8'h74;
   localparam logic [7:0] OPC_MOV_REG_A = 8'hf8;
   localparam logic [7:0] OPC_MOV_REG_DIR = 8'ha8;
   localparam logic [7:0] OPC_MOV_REG_IMM = 8'h78;
   // Masks for register and pointer forms
   localparam logic [7:0] MASK_REG = 8'hf8;
   localparam logic [7:0] MASK_IND = 8'hfe;
   // Status word bit positions
   localparam int PSW_CARRY_BIT = 7;
   localparam int PSW_BANK_HI_BIT = 4;
   localparam int PSW_BANK_LO_BIT = 3;
   // Lengths and cycle counts
   localparam logic [1:0] LEN_1 = 2'h1;
   localparam logic [1:0] LEN_2 = 2'h2;
   localparam logic [1:0] LEN_3 = 2'h3;
   localparam logic [2:0] CYC_1 = 3'h1;
   localparam logic [2:0] CYC_2 = 3'h2;
   localparam logic [2:0] CYC_3 = 3'h3;
   localparam logic [2:0] CYC_4 = 3'h4;
   // Reset values
   localparam logic [7:0] BYTE_RST = 8'h00;
   localparam logic [4:0] RADDR_RST = 5'h00;

   typedef enum logic [3:0] {
      ALU_NONE, ALU_OR, ALU_XOR, ALU_CLR, ALU_CPL, ALU_RL,
      ALU_RLC, ALU_RR, ALU_RRC, ALU_SWAP, ALU_MOVE
   } lrm_alu_t;
   typedef enum logic [2:0] {
      SRC_IMM1, SRC_IMM2, SRC_REG, SRC_DIR, SRC_IND, SRC_ACC
   } lrm_src_t;
   typedef enum logic [1:0] {DST_ACC, DST_REG, DST_DIR} lrm_dst_t;
   typedef struct packed {
      logic known;
      lrm_alu_t alu;
      lrm_src_t src;
      lrm_dst_t dst;
      logic [1:0] len;
      logic [2:0] cyc;
   } lrm_dec_t;
endpackage : lrm_pkg

// ### sim/lrm_decoder_sva.sv
module lrm_sva_checker (
   input wire logic i_ref_clk,
   input wire logic i_rst_n,
   input wire logic i_ce,
   input wire logic i_start,
   input wire logic o_busy,
   input wire logic o_done,
   input wire logic o_known,
   input wire logic [1:0] o_length,
   input wire logic [2:0] o_cycles,
   input wire logic o_acc_we,
   input wire logic [7:0] o_acc_wdata,
   input wire logic o_parity,
   input wire logic o_carry_we,
   input wire logic o_reg_we,
   input wire logic o_mem_we
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [2:0] busy_cnt_reg;

   // Counts only enabled busy cycles, so a frozen core does not skew it
   always_ff @(posedge i_ref_clk) begin
      if (!i_rst_n || !o_busy) begin
         busy_cnt_reg <= 3'h0;
      end else if (i_ce) begin
         busy_cnt_reg <= busy_cnt_reg + 3'h1;
      end
   end

   // One clock domain, so clock and reset are given once
   default clocking cb @(posedge i_ref_clk);
   endclocking
   default disable iff (!i_rst_n);

   sequence s_take;
      i_start && i_ce && !o_busy;
   endsequence
   sequence s_finish;
      $fell(o_busy) && $past(i_rst_n);
   endsequence

   a_take_known:
      assert property (s_take |=> o_busy == o_known
                       && o_known == (o_cycles != 3'h0))
      else $error("taken opcode reported wrongly");
   a_busy_ends_done:
      assert property (s_finish |-> o_done)
      else $error("busy ended without done");
   a_busy_count:
      assert property ($rose(o_done) |-> busy_cnt_reg == o_cycles)
      else $error("busy length differs from cycle count");
   a_done_pulse:
      assert property (o_done && i_ce |=> !o_done)
      else $error("done longer than one cycle");
   a_strobe_with_done:
      assert property (o_acc_we || o_reg_we || o_mem_we || o_carry_we
                       |-> o_done)
      else $error("write strobe outside done");
   a_one_dest:
      assert property (o_done |-> $onehot({o_acc_we, o_reg_we, o_mem_we}))
      else $error("not exactly one destination written");
   a_three_byte_mem:
      assert property (o_done && o_length == 2'h3 |-> o_mem_we)
      else $error("three byte form did not write direct byte");
   a_mem_four_cycles:
      assert property (o_mem_we |-> o_cycles == 3'h4 && o_length != 2'h1)
      else $error("direct write with wrong timing");
   a_carry_rotate:
      assert property (o_carry_we |-> o_acc_we && o_cycles == 3'h1
                       && o_length == 2'h1)
      else $error("carry written outside a rotate");
   a_parity_match:
      assert property (o_acc_we |-> o_parity == ^o_acc_wdata)
      else $error("parity does not match accumulator");
endmodule : lrm_sva_checker

bind lrm_decoder lrm_sva_checker u_lrm_sva_checker (
   .i_ref_clk, .i_rst_n, .i_ce, .i_start, .o_busy, .o_done, .o_known,
   .o_length, .o_cycles, .o_acc_we, .o_acc_wdata, .o_parity, .o_carry_we,
   .o_reg_we, .o_mem_we
);

// ### sim/test_logic_rotate_move_decoder.sv
module test_logic_rotate_move_decoder
   import lrm_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   typedef struct packed {
      logic [7:0] op;
      logic [1:0] len;
      logic [2:0] cyc;
      logic [1:0] dst;
      logic [7:0] res;
   } lrm_row_t;
   logic i_ref_clk, i_rst_n, i_ce, i_start;
   logic [7:0] i_opcode, i_byte1, i_byte2, i_acc, i_psw;
   logic [7:0] i_reg_rdata, i_mem_rdata, w;
   logic o_busy, o_done, o_known, o_acc_we, o_parity, o_carry_we, o_carry;
   logic o_reg_we, o_mem_we, c;
   logic [1:0] o_length;
   logic [2:0] o_cycles;
   logic [4:0] o_reg_addr;
   logic [7:0] o_mem_addr, o_acc_wdata, o_reg_wdata, o_mem_wdata;
   int err_total = 0;
   int samples_checked = 0;
   int n;
   lrm_row_t r;
   // Operands: acc a5, imm 3c, imm2 18, reg 0f, mem 66, carry 0
   lrm_row_t rows [25] = '{
      '{8'h44, 2'h2, 3'h2, 2'h0, 8'hbd}, '{8'h42, 2'h2, 3'h4, 2'h2, 8'he7},
      '{8'h43, 2'h3, 3'h4, 2'h2, 8'h7e}, '{8'h6f, 2'h1, 3'h2, 2'h0, 8'haa},
      '{8'h65, 2'h2, 3'h3, 2'h0, 8'hc3}, '{8'h66, 2'h1, 3'h4, 2'h0, 8'hc3},
      '{8'h67, 2'h1, 3'h4, 2'h0, 8'hc3}, '{8'h64, 2'h2, 3'h2, 2'h0, 8'h99},
      '{8'h62, 2'h2, 3'h4, 2'h2, 8'hc3}, '{8'h63, 2'h3, 3'h4, 2'h2, 8'h7e},
      '{8'he4, 2'h1, 3'h1, 2'h0, 8'h00}, '{8'hf4, 2'h1, 3'h1, 2'h0, 8'h5a},
      '{8'h23, 2'h1, 3'h1, 2'h0, 8'h4b}, '{8'h33, 2'h1, 3'h1, 2'h0, 8'h4a},
      '{8'h03, 2'h1, 3'h1, 2'h0, 8'hd2}, '{8'h13, 2'h1, 3'h1, 2'h0, 8'h52},
      '{8'hc4, 2'h1, 3'h1, 2'h0, 8'h5a}, '{8'heb, 2'h1, 3'h1, 2'h0, 8'h0f},
      '{8'he5, 2'h2, 3'h3, 2'h0, 8'h66}, '{8'he6, 2'h1, 3'h4, 2'h0, 8'h66},
      '{8'he7, 2'h1, 3'h4, 2'h0, 8'h66}, '{8'h74, 2'h2, 3'h2, 2'h0, 8'h3c},
      '{8'hfd, 2'h1, 3'h1, 2'h1, 8'ha5}, '{8'haa, 2'h2, 3'h4, 2'h1, 8'h66},
      '{8'h7e, 2'h2, 3'h2, 2'h1, 8'h3c}};

   lrm_decoder u_lrm_decoder (
      .i_ref_clk, .i_rst_n, .i_ce, .i_start, .i_opcode, .i_byte1, .i_byte2,
      .i_acc, .i_psw, .i_reg_rdata, .i_mem_rdata, .o_busy, .o_done, .o_known,
      .o_length, .o_cycles, .o_reg_addr, .o_mem_addr, .o_acc_we,
      .o_acc_wdata, .o_parity, .o_carry_we, .o_carry, .o_reg_we,
      .o_reg_wdata, .o_mem_we, .o_mem_wdata
   );

   // Free running 100 MHz clock
   initial begin
      i_ref_clk = 1'b0;
      forever #5 i_ref_clk = ~i_ref_clk;
   end

   task automatic final_report();
      $display("mismatches %0d of %0d checks", err_total, samples_checked);
      if (err_total == 0 && samples_checked > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask : final_report

   task automatic chk(input string nm, input logic [7:0] got,
                      input logic [7:0] exp);
      samples_checked++;
      if (got !== exp) begin
         err_total++;
         $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
      end
   endtask : chk

   // Counts busy cycles; leaves the caller in the done cycle
   task automatic run(input logic [7:0] opc);
      @(posedge i_ref_clk);
      i_opcode <= opc;
      i_start <= 1'b1;
      @(posedge i_ref_clk);
      i_start <= 1'b0;
      #1;
      n = 0;
      while (o_busy === 1'b1) begin
         n++;
         if (n > 8) begin
            err_total++;
            final_report();
         end
         @(posedge i_ref_clk);
         #1;
      end
   endtask : run

   task automatic reset_for(input int cycles);
      i_rst_n <= 1'b0;
      repeat (cycles) @(posedge i_ref_clk);
      i_rst_n <= 1'b1;
      #1;
      chk("reset", {o_busy, o_done, o_known, o_length, o_cycles}, 8'h00);
      chk("reset we", {4'h0, o_acc_we, o_reg_we, o_mem_we, o_carry_we}, 8'h0);
   endtask : reset_for

   initial begin
      i_rst_n = 1'b0;
      i_ce = 1'b1;
      i_start = 1'b0;
      i_opcode = 8'h00;
      i_byte1 = 8'h3c;
      i_byte2 = 8'h18;
      i_acc = 8'ha5;
      i_psw = 8'h18;
      i_reg_rdata = 8'h0f;
      i_mem_rdata = 8'h66;
      reset_for(12);
      foreach (rows[k]) begin
         r = rows[k];
         run(r.op);
         c = (r.op == 8'h33 || r.op == 8'h13);
         w = (r.dst == 2'h0) ? o_acc_wdata :
             (r.dst == 2'h1) ? o_reg_wdata : o_mem_wdata;
         chk("done", {7'h0, o_done}, 8'h01);
         chk("length", {6'h0, o_length}, {6'h0, r.len});
         chk("cycles", {5'h0, o_cycles}, {5'h0, r.cyc});
         chk("busy run", 8'(n), {5'h0, r.cyc});
         chk("dest", {5'h0, o_acc_we, o_reg_we, o_mem_we},
             8'h04 >> r.dst);
         chk("result", w, r.res);
         chk("carry", {6'h0, o_carry_we, o_carry}, {6'h0, c, c});
         if (r.dst == 2'h0)
            chk("parity", {7'h0, o_parity}, {7'h0, ^r.res});
         if ((r.op & MASK_IND) inside {8'h66, 8'he6}) begin
            // Bank 3 from the status word, pointer index in bit 0
            chk("ptr", {3'h0, o_reg_addr}, {3'h0, 4'hc, r.op[0]});
            chk("ptr addr", o_mem_addr, 8'h0f);
         end
         if ((r.op & MASK_REG) inside {8'h68, 8'he8, 8'hf8, 8'ha8, 8'h78})
            chk("reg", {3'h0, o_reg_addr}, {5'h03, r.op[2:0]});
         if (r.dst == 2'h2 || r.op inside {8'h65, 8'he5, 8'haa})
            chk("direct", o_mem_addr, 8'h3c);
      end
      // Opcode outside the set is refused
      run(8'h45);
      chk("unknown", {o_known, o_done, o_length, o_cycles, 1'b0}, 8'h00);
      // Every bank chosen by status bits 4 and 3
      for (int b = 0; b < 4; b++) begin
         @(posedge i_ref_clk);
         i_psw <= {3'h0, 2'(b), 3'h0};
         run(8'hf9);
         chk("bank", {3'h0, o_reg_addr}, {3'h0, 2'(b), 3'h1});
      end
      // Start offered while busy is ignored; clock enable freezes the run
      @(posedge i_ref_clk);
      i_psw <= 8'h18;
      i_opcode <= 8'ha9;
      i_start <= 1'b1;
      @(posedge i_ref_clk);
      i_opcode <= 8'he4;
      @(posedge i_ref_clk);
      i_start <= 1'b0;
      i_ce <= 1'b0;
      repeat (3) @(posedge i_ref_clk);
      i_ce <= 1'b1;
      #1;
      n = 0;
      while (o_done !== 1'b1 && n < 9) begin
         n++;
         @(posedge i_ref_clk);
         #1;
      end
      // One enabled busy edge ran before the freeze, three remain after
      chk("frozen run", 8'(n), 8'h03);
      chk("kept length", {6'h0, o_length}, 8'h02);
      chk("kept data", o_reg_wdata, 8'h66);
      chk("kept reg", {3'h0, o_reg_addr}, 8'h19);
      // Reset in mid-run clears everything and the core recovers
      @(posedge i_ref_clk);
      i_opcode <= 8'h42;
      i_start <= 1'b1;
      @(posedge i_ref_clk);
      i_start <= 1'b0;
      repeat (2) @(posedge i_ref_clk);
      reset_for(2);
      run(8'h44);
      chk("after reset", o_acc_wdata, 8'hbd);
      final_report();
   end
endmodule : test_logic_rotate_move_decoder
